// File: hdl/mfd_detector.v
`timescale 1ns/1ps
`include "mfd_regs.vh"
// Behaviour
// - Partial half-word write aimed at accumulator or quotient is a storage fault.
// - Read or write to an unassigned address is a storage fault.
// - Reading accumulator during phase 7 is a storage fault.
// - Tape instruction storage reference outside core store is a storage fault.
// - Storage fault sets its flag, combined fault, and recoverable class.
// - Combined decode-or-storage fault stops the controlled clock immediately.
// - Divide check failure sets divide flag, recoverable class, and stop.
// - Untranslatable print code raises a recoverable print fault.
// - Loss of water pressure raises a recoverable water fault.
// - Open temperature interlock faults unless bypassed; bypass sounds continuous alarm.
// - In normal mode abnormal switch settings fault; in test mode they never stop.
// - Multiply with accumulator bits 34 and 35 unequal raises overflow stop.
// - Severe fault halts clock, drops operate, and clears start selections.
// - Invalid opcode at phase 0 sets decode flag, severe class, immediate stop.
// - Tape line pulses are counted; block pulse at block length.
// - Line pulse during block pulse sets tape error, severe fault.
// - Reel-end gap line pulses trigger the same tape fault.
// - Power supply bias fault raises severe voltage fault and indication.
// - Recoverable fault keeps state; clear-recoverable resets its detection flags.
// - Read sets channel pending flag; read or write while pending faults.
module mfd_detector
(
    input wire CLK,
    input wire RST_B,
    // Storage reference strobes and address class enables.
    input wire WRITE_LOW_REQ,
    input wire WRITE_HIGH_REQ,
    input wire WRITE_FULL_REQ,
    input wire READ_REQ,
    input wire READ_ACC_REQ,
    input wire STORAGE_DONE,
    input wire SEL_ACC,
    input wire SEL_QUO,
    input wire SEL_CORE,
    input wire SEL_DRUM,
    // Instruction timing and decode.
    input wire [2:0] TIMING_PHASE,
    input wire [5:0] INSTRUCTION_HOLD_REGISTER,
    // Arithmetic checks.
    input wire DIVIDE_CHECK_FAIL,
    input wire MULTIPLY_START,
    input wire ACC_BIT34,
    input wire ACC_BIT35,
    // Output translation.
    input wire PRINT_STROBE,
    input wire [5:0] PRINT_CODE,
    // Tape reading.
    input wire TAPE_READING,
    input wire LINE_PULSE,
    // Channel handshakes.
    input wire CHAN_A_READ,
    input wire CHAN_A_WRITE,
    input wire CHAN_A_DONE,
    input wire CHAN_B_READ,
    input wire CHAN_B_WRITE,
    input wire CHAN_B_DONE,
    // Plant contacts, asynchronous to the clock.
    input wire WATER_PRESSURE_OK,
    input wire TEMP_INTERLOCK_CLOSED,
    input wire BYPASS_INTERLOCKS,
    input wire MAIN_POWER_AT_OPERATE,
    input wire CORE_POWER_AT_OPERATE,
    input wire TEST_SWITCHES_NORMAL,
    input wire TEST_MODE,
    input wire MAIN_BIAS_FAULT,
    input wire CORE_BIAS_FAULT,
    // Operator controls.
    input wire MASTER_CLEAR,
    input wire CLEAR_RECOVERABLE,
    input wire START_SELECT,
    input wire START,
    // Outputs.
    output reg CLOCK_RUN,
    output reg OPERATE,
    output reg START_SELECTED,
    output reg DECODE_OR_STORAGE_FAULT,
    output reg RECOVERABLE_FAULT,
    output reg SEVERE_FAULT,
    output reg IMMEDIATE_STOP,
    output reg ALARM,
    output reg CHAN_A_READ_PENDING,
    output reg CHAN_B_READ_PENDING,
    output reg BLOCK_PULSE,
    output reg [`MFD_IND_W-1:0] FAULT_IND
);
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Invalid operation codes; everything else is accepted at phase 0.
    function opcode_invalid;
        input [5:0] op;
        begin
            case (op)
                6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                6'h08, 6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38, 6'h12,
                6'h14, 6'h15, 6'h16, 6'h32:
                    opcode_invalid = 1'b1;
                default:
                    opcode_invalid = 1'b0;
            endcase
        end
    endfunction

    // Printable codes; the unused top of the code space is rejected.
    function print_invalid;
        input [5:0] code;
        begin
            print_invalid = (code >= 6'h3C);
        end
    endfunction

    // ----------------------------------------
    // Plant input synchronisation
    // ----------------------------------------
    wire [6:0] plant_sync;
    wire water_ok = plant_sync[0];
    wire temp_ok = plant_sync[1];
    wire bypass = plant_sync[2];
    wire main_op = plant_sync[3];
    wire core_op = plant_sync[4];
    wire sw_norm = plant_sync[5];
    wire bias_bad = plant_sync[6];
    mfd_sync #(.W(7)) u_sync
    (
        .clk(CLK),
        .rst_b(RST_B),
        .din({MAIN_BIAS_FAULT | CORE_BIAS_FAULT, TEST_SWITCHES_NORMAL, CORE_POWER_AT_OPERATE,
            MAIN_POWER_AT_OPERATE, BYPASS_INTERLOCKS, TEMP_INTERLOCK_CLOSED, WATER_PRESSURE_OK}),
        .dout(plant_sync)
    );
    reg test_mode_ff;

    // ----------------------------------------
    // Tape block check
    // ----------------------------------------
    wire tape_err;
    wire block_pulse;
    mfd_tape_check u_tape
    (
        .clk(CLK),
        .rst_b(RST_B),
        .tape_reading(TAPE_READING),
        .line_pulse(LINE_PULSE),
        .block_pulse_ff(block_pulse),
        .line_error(tape_err)
    );

    // ----------------------------------------
    // Fault detection terms
    // ----------------------------------------
    wire unassigned = !(SEL_ACC | SEL_QUO | SEL_CORE | SEL_DRUM);
    wire partial = WRITE_LOW_REQ | WRITE_HIGH_REQ;
    wire st_partial = partial & (SEL_ACC | SEL_QUO);
    wire st_unassigned = (partial | WRITE_FULL_REQ | READ_REQ) & unassigned;
    wire st_acc_fetch = READ_ACC_REQ & (TIMING_PHASE == `MFD_PHASE_NEXT);
    wire tape_op = (INSTRUCTION_HOLD_REGISTER == `MFD_OP_TAPE_WRITE) ||
        (INSTRUCTION_HOLD_REGISTER == `MFD_OP_TAPE_READ);
    wire st_tape = STORAGE_DONE & tape_op & !SEL_CORE;
    wire storage_evt = st_partial | st_unassigned | st_acc_fetch | st_tape;
    wire decode_evt = (TIMING_PHASE == `MFD_PHASE_FETCH) && opcode_invalid(INSTRUCTION_HOLD_REGISTER);
    wire print_evt = PRINT_STROBE & print_invalid(PRINT_CODE);
    wire overflow_evt = MULTIPLY_START & (ACC_BIT34 ^ ACC_BIT35);
    // Plant faults are levels; the flag holds while the condition lasts.
    wire water_evt = !water_ok;
    wire temp_evt = !temp_ok & !bypass;
    wire abnormal_evt = !test_mode_ff & !(main_op & core_op & sw_norm);
    wire io_evt = ((CHAN_A_READ | CHAN_A_WRITE) & CHAN_A_READ_PENDING) |
        ((CHAN_B_READ | CHAN_B_WRITE) & CHAN_B_READ_PENDING);

    wire [`MFD_IND_W-1:0] evt;
    assign evt[`MFD_IND_STORAGE] = storage_evt;
    assign evt[`MFD_IND_DIVIDE] = DIVIDE_CHECK_FAIL;
    assign evt[`MFD_IND_PRINT] = print_evt;
    assign evt[`MFD_IND_WATER] = water_evt;
    assign evt[`MFD_IND_TEMP] = temp_evt;
    assign evt[`MFD_IND_ABNORMAL] = abnormal_evt;
    assign evt[`MFD_IND_OVERFLOW] = overflow_evt;
    assign evt[`MFD_IND_DECODE] = decode_evt;
    assign evt[`MFD_IND_TAPE] = tape_err;
    assign evt[`MFD_IND_VOLTAGE] = bias_bad;
    assign evt[`MFD_IND_IO] = io_evt;

    // Recoverable class occupies the low seven indicator bits.
    localparam [`MFD_IND_W-1:0] RECOV_MASK = 11'h07F;
    localparam [`MFD_IND_W-1:0] STOP_MASK = 11'h0C3;

    // ----------------------------------------
    // Latched indicators
    // ----------------------------------------
    // A new event wins over a clear in the same cycle.
    reg [`MFD_IND_W-1:0] nxt_ind;
    always @*
    begin
        nxt_ind = FAULT_IND;
        if (MASTER_CLEAR)
            nxt_ind = {`MFD_IND_W{1'b0}};
        else if (CLEAR_RECOVERABLE)
            nxt_ind = FAULT_IND & ~RECOV_MASK;
        nxt_ind = nxt_ind | evt;
    end

    // Combined class outputs from the next indicator state so all flip-flops agree.
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            FAULT_IND <= {`MFD_IND_W{1'b0}};
            DECODE_OR_STORAGE_FAULT <= 1'b0;
            RECOVERABLE_FAULT <= 1'b0;
            SEVERE_FAULT <= 1'b0;
            IMMEDIATE_STOP <= 1'b0;
            ALARM <= 1'b0;
            test_mode_ff <= 1'b0;
        end
        else
        begin
            FAULT_IND <= nxt_ind;
            DECODE_OR_STORAGE_FAULT <= nxt_ind[`MFD_IND_STORAGE] | nxt_ind[`MFD_IND_DECODE];
            RECOVERABLE_FAULT <= |(nxt_ind & RECOV_MASK & ~(11'h020 & {11{test_mode_ff}}));
            SEVERE_FAULT <= |(nxt_ind & ~RECOV_MASK);
            IMMEDIATE_STOP <= |(nxt_ind & STOP_MASK);
            ALARM <= bypass;
            test_mode_ff <= TEST_MODE;
        end
    end

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    // Any fault halts the clock, save the abnormal-settings flag alone in test mode; severe faults also drop the start selection.
    wire any_fault = |nxt_ind && !(nxt_ind == 11'h020 && test_mode_ff);
    wire severe = |(nxt_ind & ~RECOV_MASK);
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            CLOCK_RUN <= 1'b0;
            OPERATE <= 1'b0;
            START_SELECTED <= 1'b0;
        end
        else
        begin
            if (MASTER_CLEAR || severe)
                START_SELECTED <= 1'b0;
            else if (START_SELECT)
                START_SELECTED <= 1'b1;
            if (any_fault || MASTER_CLEAR)
            begin
                CLOCK_RUN <= 1'b0;
                OPERATE <= 1'b0;
            end
            else if (START && START_SELECTED)
            begin
                CLOCK_RUN <= 1'b1;
                OPERATE <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Channel read pending flags
    // ----------------------------------------
    // A read that coincides with completion still leaves the flag set.
    always @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            CHAN_A_READ_PENDING <= 1'b0;
            CHAN_B_READ_PENDING <= 1'b0;
            BLOCK_PULSE <= 1'b0;
        end
        else
        begin
            if (MASTER_CLEAR)
                CHAN_A_READ_PENDING <= 1'b0;
            else if (CHAN_A_READ)
                CHAN_A_READ_PENDING <= 1'b1;
            else if (CHAN_A_DONE)
                CHAN_A_READ_PENDING <= 1'b0;
            if (MASTER_CLEAR)
                CHAN_B_READ_PENDING <= 1'b0;
            else if (CHAN_B_READ)
                CHAN_B_READ_PENDING <= 1'b1;
            else if (CHAN_B_DONE)
                CHAN_B_READ_PENDING <= 1'b0;
            BLOCK_PULSE <= block_pulse;
        end
    end
endmodule // mfd_detector

// File: hdl/mfd_regs.vh
`ifndef MFD_REGS_VH
`define MFD_REGS_VH
// ----------------------------------------
// Timing and sizing constants
// ----------------------------------------
// Clock period in ns.
`define MFD_CLK_PERIOD_NS 50
// Lines in one tape block.
`define MFD_BLOCK_LINES 576
// Width of the line counter.
`define MFD_LINE_CNT_W 10
// Phase codes of the timing phase counter.
`define MFD_PHASE_FETCH 3'h0
`define MFD_PHASE_NEXT 3'h7
// Tape instruction codes.
`define MFD_OP_TAPE_WRITE 6'h34
`define MFD_OP_TAPE_READ 6'h35
// Indicator vector bit positions.
`define MFD_IND_STORAGE 0
`define MFD_IND_DIVIDE 1
`define MFD_IND_PRINT 2
`define MFD_IND_WATER 3
`define MFD_IND_TEMP 4
`define MFD_IND_ABNORMAL 5
`define MFD_IND_OVERFLOW 6
`define MFD_IND_DECODE 7
`define MFD_IND_TAPE 8
`define MFD_IND_VOLTAGE 9
`define MFD_IND_IO 10
`define MFD_IND_W 11
`endif

// File: hdl/mfd_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// Three-stage input synchroniser with agreement filter
// ----------------------------------------
module mfd_sync
#(
    parameter W = 1
)
(
    input wire clk,
    input wire rst_b,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    integer i;

    // The output only follows once the second and third stages agree.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            dout <= {W{1'b0}};
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (i = 0; i < W; i = i + 1)
                if (s2_ff[i] == s3_ff[i])
                    dout[i] <= s3_ff[i];
        end
    end
endmodule // mfd_sync

// File: hdl/mfd_tape_check.v
`timescale 1ns/1ps
`include "mfd_regs.vh"
// ----------------------------------------
// Tape line pulse counter and block check
// ----------------------------------------
module mfd_tape_check
#(
    parameter BLOCK_LINES = `MFD_BLOCK_LINES,
    parameter CNT_W = `MFD_LINE_CNT_W
)
(
    input wire clk,
    input wire rst_b,
    input wire tape_reading,
    input wire line_pulse,
    output reg block_pulse_ff,
    output wire line_error
);
    localparam [CNT_W-1:0] LAST = BLOCK_LINES - 1;
    reg [CNT_W-1:0] count_ff;

    // Count lines while reading; the block pulse follows the last line of a block.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_ff <= {CNT_W{1'b0}};
            block_pulse_ff <= 1'b0;
        end
        else if (!tape_reading)
        begin
            count_ff <= {CNT_W{1'b0}};
            block_pulse_ff <= 1'b0;
        end
        else if (line_pulse && !block_pulse_ff)
        begin
            block_pulse_ff <= (count_ff == LAST);
            count_ff <= (count_ff == LAST) ? {CNT_W{1'b0}} : count_ff + 1'b1;
        end
        else if (!line_pulse)
            block_pulse_ff <= 1'b0;
    end

    // A line arriving while the block pulse stands means a wrong count or a reel-end marker.
    assign line_error = tape_reading && line_pulse && block_pulse_ff;
endmodule // mfd_tape_check

// File: verif/mfd_chan_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Channel controller model
// ----------------------------------------
module mfd_chan_model
(
    input wire clk,
    input wire rst_b,
    input wire go,
    input wire rude,
    input wire pending,
    output reg read_ff
);
    // A polite controller waits until the previous read data was absorbed.
    // The rude flavour ignores that on purpose, only where a scenario asks for the fault.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            read_ff <= 1'b0;
        else
            read_ff <= go && !read_ff && (rude || !pending);
    end
endmodule // mfd_chan_model

// File: verif/mfd_detector_properties.sv
`timescale 1ns/1ps
`include "mfd_regs.vh"
// ----------------------------------------
// Port level checks of the fault detector
// ----------------------------------------
module mfd_detector_properties
(
    input wire CLK,
    input wire RST_B,
    input wire WRITE_LOW_REQ,
    input wire WRITE_HIGH_REQ,
    input wire WRITE_FULL_REQ,
    input wire READ_REQ,
    input wire READ_ACC_REQ,
    input wire STORAGE_DONE,
    input wire SEL_ACC,
    input wire SEL_QUO,
    input wire SEL_CORE,
    input wire SEL_DRUM,
    input wire [2:0] TIMING_PHASE,
    input wire [5:0] INSTRUCTION_HOLD_REGISTER,
    input wire DIVIDE_CHECK_FAIL,
    input wire MULTIPLY_START,
    input wire ACC_BIT34,
    input wire ACC_BIT35,
    input wire PRINT_STROBE,
    input wire [5:0] PRINT_CODE,
    input wire CHAN_A_READ,
    input wire LINE_PULSE,
    input wire MASTER_CLEAR,
    input wire CLOCK_RUN,
    input wire OPERATE,
    input wire START_SELECTED,
    input wire DECODE_OR_STORAGE_FAULT,
    input wire RECOVERABLE_FAULT,
    input wire SEVERE_FAULT,
    input wire IMMEDIATE_STOP,
    input wire CHAN_A_READ_PENDING,
    input wire BLOCK_PULSE,
    input wire [`MFD_IND_W-1:0] FAULT_IND
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // Every cause is tied to its indicator one cycle later, as the hand-over fixes it; the invalid opcode check allows one or two cycles.
    part_write_a: assert property (
        (WRITE_LOW_REQ || WRITE_HIGH_REQ) && (SEL_ACC || SEL_QUO)
        |=> FAULT_IND[`MFD_IND_STORAGE] && DECODE_OR_STORAGE_FAULT && RECOVERABLE_FAULT)
        else $error("partial write to acc or quotient not flagged");
    unassigned_addr_a: assert property (
        (WRITE_LOW_REQ || WRITE_HIGH_REQ || WRITE_FULL_REQ || READ_REQ)
        && !(SEL_ACC || SEL_QUO || SEL_CORE || SEL_DRUM) |=> FAULT_IND[`MFD_IND_STORAGE])
        else $error("unassigned address not flagged");
    acc_fetch_a: assert property (
        READ_ACC_REQ && TIMING_PHASE == `MFD_PHASE_NEXT |=> FAULT_IND[`MFD_IND_STORAGE])
        else $error("accumulator fetch not flagged");
    tape_core_a: assert property (
        STORAGE_DONE && !SEL_CORE && INSTRUCTION_HOLD_REGISTER inside {`MFD_OP_TAPE_WRITE, `MFD_OP_TAPE_READ}
        |=> FAULT_IND[`MFD_IND_STORAGE])
        else $error("tape reference outside core not flagged");
    fast_stop_a: assert property (
        $rose(DECODE_OR_STORAGE_FAULT) |-> IMMEDIATE_STOP && !CLOCK_RUN)
        else $error("combined fault did not stop at once");
    divide_check_a: assert property (
        DIVIDE_CHECK_FAIL |=> FAULT_IND[`MFD_IND_DIVIDE] && RECOVERABLE_FAULT && IMMEDIATE_STOP)
        else $error("divide fault missing");
    print_code_a: assert property (
        PRINT_STROBE && PRINT_CODE >= 6'h3C |=> FAULT_IND[`MFD_IND_PRINT] && RECOVERABLE_FAULT)
        else $error("print fault missing");
    mul_overflow_a: assert property (
        MULTIPLY_START && (ACC_BIT34 != ACC_BIT35) |=> FAULT_IND[`MFD_IND_OVERFLOW] && IMMEDIATE_STOP)
        else $error("overflow fault missing");
    severe_drop_a: assert property (
        $rose(SEVERE_FAULT) |-> !START_SELECTED && !OPERATE && !CLOCK_RUN)
        else $error("severe fault kept run state");
    bad_opcode_a: assert property (
        TIMING_PHASE == `MFD_PHASE_FETCH && INSTRUCTION_HOLD_REGISTER inside {6'h08, 6'h10, 6'h32}
        |=> ##[0:1] FAULT_IND[`MFD_IND_DECODE] && SEVERE_FAULT && DECODE_OR_STORAGE_FAULT)
        else $error("invalid opcode not flagged");
    reread_a: assert property (
        CHAN_A_READ && CHAN_A_READ_PENDING |=> FAULT_IND[`MFD_IND_IO] && SEVERE_FAULT)
        else $error("second read not flagged");
    ind_held_a: assert property (
        $fell(FAULT_IND[`MFD_IND_VOLTAGE]) |-> $past(MASTER_CLEAR))
        else $error("voltage indicator dropped without clear");
    block_after_line_a: assert property (
        $rose(BLOCK_PULSE) |-> $past(LINE_PULSE, 2))
        else $error("block pulse without a counted line");

    // Main scenarios reached.
    cover property (BLOCK_PULSE);
    cover property ($rose(RECOVERABLE_FAULT));
    cover property (CHAN_A_READ && CHAN_A_READ_PENDING);
endmodule // mfd_detector_properties

// File: verif/mfd_detector_test.sv
`timescale 1ns/1ps
`include "mfd_regs.vh"
// ----------------------------------------
// Fault detector bench
// ----------------------------------------
module mfd_detector_test;
    reg CLK, RST_B, WRITE_LOW_REQ, WRITE_HIGH_REQ, WRITE_FULL_REQ, READ_REQ, READ_ACC_REQ, STORAGE_DONE;
    reg SEL_ACC, SEL_QUO, SEL_CORE, SEL_DRUM, DIVIDE_CHECK_FAIL, MULTIPLY_START, ACC_BIT34, ACC_BIT35;
    reg PRINT_STROBE, TAPE_READING, LINE_PULSE, CHAN_A_WRITE, CHAN_A_DONE, CHAN_B_WRITE, CHAN_B_DONE;
    reg WATER_PRESSURE_OK, TEMP_INTERLOCK_CLOSED, BYPASS_INTERLOCKS, MAIN_POWER_AT_OPERATE, CORE_POWER_AT_OPERATE;
    reg TEST_SWITCHES_NORMAL, TEST_MODE, MAIN_BIAS_FAULT, CORE_BIAS_FAULT, MASTER_CLEAR, CLEAR_RECOVERABLE;
    reg START_SELECT, START, go_a, go_b, look;
    reg [2:0] TIMING_PHASE;
    reg [5:0] INSTRUCTION_HOLD_REGISTER, PRINT_CODE;
    reg [7:0] rnd;
    reg [20:0] ex;
    reg [20:0] exp_tab [0:24];
    wire CHAN_A_READ, CHAN_B_READ, CLOCK_RUN, OPERATE, START_SELECTED, DECODE_OR_STORAGE_FAULT, ALARM;
    wire RECOVERABLE_FAULT, SEVERE_FAULT, IMMEDIATE_STOP, CHAN_A_READ_PENDING, CHAN_B_READ_PENDING, BLOCK_PULSE;
    wire [`MFD_IND_W-1:0] FAULT_IND;
    logic [20:0] exp_q[$];
    logic [20:0] msk_q[$];
    integer mismatches = 0, total_checks = 0, cyc = 0, k;
    localparam [20:0] NOPEND = 21'h07FFFF;

    mfd_detector u_mfd_detector (.*);
    mfd_chan_model u_mfd_chan_model_a (.clk(CLK), .rst_b(RST_B), .go(go_a), .rude(1'b1),
        .pending(CHAN_A_READ_PENDING), .read_ff(CHAN_A_READ));
    mfd_chan_model u_mfd_chan_model_b (.clk(CLK), .rst_b(RST_B), .go(go_b), .rude(1'b0),
        .pending(CHAN_B_READ_PENDING), .read_ff(CHAN_B_READ));

    // Free running 20 MHz clock.
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // Hang guard: the whole run needs about 1860 cycles.
    always @(posedge CLK)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            mismatches = mismatches + 1;
            close_out;
        end
    end

    // Monitor takes the oldest note whenever the driver flags a result.
    always @(posedge CLK)
    begin
        if (look)
            cmp(exp_q.pop_front(), msk_q.pop_front(), {CHAN_A_READ_PENDING, CHAN_B_READ_PENDING, ALARM,
                START_SELECTED, OPERATE, CLOCK_RUN, SEVERE_FAULT, RECOVERABLE_FAULT, DECODE_OR_STORAGE_FAULT,
                IMMEDIATE_STOP, FAULT_IND});
    end

    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task tick(input integer n);
        repeat (n) @(posedge CLK);
    endtask

    task cmp(input [20:0] e, input [20:0] m, input [20:0] g);
        total_checks = total_checks + 1;
        if ((g & m) !== (e & m))
        begin
            mismatches = mismatches + 1;
            $display("ERROR status expected %h seen %h", e & m, g & m);
        end
    endtask

    // Back to back calls are never made, so look is never driven twice in one step.
    task chk(input [20:0] e, input [20:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        look <= 1'b1;
        tick(1);
        look <= 1'b0;
    endtask

    // Plant contacts rest at their healthy levels so that no stray fault appears.
    task idle;
        {WRITE_LOW_REQ, WRITE_HIGH_REQ, WRITE_FULL_REQ, READ_REQ, READ_ACC_REQ, STORAGE_DONE} <= 6'h00;
        {SEL_ACC, SEL_QUO, SEL_CORE, SEL_DRUM, DIVIDE_CHECK_FAIL, MULTIPLY_START, ACC_BIT34, ACC_BIT35} <= 8'h00;
        {PRINT_STROBE, CHAN_A_WRITE, CHAN_A_DONE, CHAN_B_WRITE, CHAN_B_DONE, go_a, go_b, BYPASS_INTERLOCKS} <= 8'h00;
        {WATER_PRESSURE_OK, TEMP_INTERLOCK_CLOSED, MAIN_POWER_AT_OPERATE, CORE_POWER_AT_OPERATE} <= 4'hF;
        {TEST_SWITCHES_NORMAL, MAIN_BIAS_FAULT, CORE_BIAS_FAULT} <= 3'h4;
        {TIMING_PHASE, INSTRUCTION_HOLD_REGISTER, PRINT_CODE} <= 15'h1240;
    endtask

    task pulse_start;
        START <= 1'b1;
        tick(1);
        START <= 1'b0;
        tick(2);
    endtask

    task arm;
        {MASTER_CLEAR, TEST_MODE} <= 2'h2;
        tick(1);
        {MASTER_CLEAR, START_SELECT} <= 2'h1;
        tick(1);
        START_SELECT <= 1'b0;
        pulse_start;
    endtask

    // One stimulus per case, held long enough for the plant synchronisers.
    task fire(input integer k);
        rnd = lfsr(rnd);
        ex = exp_tab[k];
        case (k)
            0: {WRITE_LOW_REQ, SEL_ACC} <= 2'h3;
            1: {WRITE_HIGH_REQ, SEL_QUO} <= 2'h3;
            2: WRITE_FULL_REQ <= 1'b1;
            3: READ_REQ <= 1'b1;
            4: {READ_ACC_REQ, SEL_ACC, TIMING_PHASE} <= 5'h1F;
            5: {STORAGE_DONE, SEL_DRUM, INSTRUCTION_HOLD_REGISTER} <= 8'hF4;
            6: {STORAGE_DONE, SEL_ACC, INSTRUCTION_HOLD_REGISTER} <= 8'hF5;
            7: {WRITE_LOW_REQ, SEL_CORE, STORAGE_DONE, INSTRUCTION_HOLD_REGISTER} <= 9'h1F4;
            8: DIVIDE_CHECK_FAIL <= 1'b1;
            9: {PRINT_STROBE, PRINT_CODE} <= {3'h7, 2'h3, rnd[1:0]};
            10: {PRINT_STROBE, PRINT_CODE, MULTIPLY_START, ACC_BIT34, ACC_BIT35} <=
                {1'b1, 6'(rnd % 8'h3C), 1'b1, rnd[0], rnd[0]};
            11: {MULTIPLY_START, ACC_BIT34, ACC_BIT35} <= {1'b1, rnd[0], ~rnd[0]};
            12, 23, 24: {TIMING_PHASE, INSTRUCTION_HOLD_REGISTER} <=
                {3'h0, (k == 12) ? 6'h08 : ((k == 23) ? 6'h10 : 6'h32)};
            13: {TIMING_PHASE, INSTRUCTION_HOLD_REGISTER} <= 9'h034;
            14: WATER_PRESSURE_OK <= 1'b0;
            15: TEMP_INTERLOCK_CLOSED <= 1'b0;
            16: {TEMP_INTERLOCK_CLOSED, BYPASS_INTERLOCKS} <= 2'h1;
            17: MAIN_POWER_AT_OPERATE <= 1'b0;
            18: {CORE_POWER_AT_OPERATE, TEST_SWITCHES_NORMAL, TEST_MODE} <= 3'h1;
            19: {MAIN_BIAS_FAULT, CORE_BIAS_FAULT} <= {rnd[0], ~rnd[0]};
            20: go_a <= 1'b1;
            21: go_b <= 1'b1;
            22: {go_b, CHAN_B_WRITE} <= 2'h3;
            default: ;
        endcase
        tick(8);
        chk(ex, (k == 18) ? 21'h1FF800 : ((k == 20 || k == 22) ? NOPEND : 21'h1FFFFF));
        idle;
        tick(8);
    endtask

    task close_out;
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence: reset, 25 cases covering each fault kind but the tape fault, and fault-free cases, then the tape block count and its tape fault.
    initial
    begin
        exp_tab = '{21'h023801, 21'h023801, 21'h023801, 21'h023801, 21'h023801, 21'h023801, 21'h023801,
            21'h038000, 21'h022802, 21'h022004, 21'h038000, 21'h022840, 21'h005880, 21'h038000, 21'h022008,
            21'h022010, 21'h078000, 21'h022020, 21'h038000, 21'h004200, 21'h004400, 21'h0B8000, 21'h004400,
            21'h005880, 21'h005880};
        RST_B <= 1'b0;
        {TAPE_READING, LINE_PULSE, TEST_MODE, MASTER_CLEAR, CLEAR_RECOVERABLE, START_SELECT, START, look} <= 8'h00;
        rnd = 8'h15;
        idle;
        tick(2);
        RST_B <= 1'b1;
        // The plant synchronisers read as faults until they have filled, so wait them out.
        tick(6);
        for (k = 0; k < 25; k = k + 1)
        begin
            arm;
            fire(k);
            CLEAR_RECOVERABLE <= 1'b1;
            tick(1);
            CLEAR_RECOVERABLE <= 1'b0;
            pulse_start;
            chk(ex[14] ? ex : 21'h038000, NOPEND);
        end
        arm;
        TAPE_READING <= 1'b1;
        LINE_PULSE <= 1'b1;
        tick(576);
        LINE_PULSE <= 1'b0;
        tick(10);
        chk(21'h038000, NOPEND);
        LINE_PULSE <= 1'b1;
        tick(577);
        LINE_PULSE <= 1'b0;
        tick(6);
        chk(21'h004100, NOPEND);
        close_out;
    end
endmodule // mfd_detector_test

bind mfd_detector mfd_detector_properties u_mfd_detector_properties (.*);
